// ---- hw/resv_pkg.sv ----
// constants and types for the reservation and barrier unit
package resv_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int GRANULE_BITS = 5;
    localparam int REG_IDX_W = 5;
    localparam int RECORD_BIT_POS = 31;
    localparam int ALIGN_BITS = 2;
    localparam logic [4:0] ZERO_BASE_IDX = 5'h00;
    localparam logic RESV_VALID_RST = 1'b0;
    localparam logic [31:0] RESV_ADDR_RST = 32'h0000_0000;
    localparam logic [7:0] DRAIN_CNT_RST = 8'h00;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_LOAD_RESERVE,
        OP_STORE_COND,
        OP_FULL_BARRIER
    } op_e;

    typedef enum logic [3:0] {
        SNOOP_NONE,
        SNOOP_STORE,
        SNOOP_ZERO,
        SNOOP_REF_CHG,
        SNOOP_TOUCH_STORE,
        SNOOP_BLOCK_STORE,
        SNOOP_FLUSH,
        SNOOP_INVALIDATE,
        SNOOP_ALLOCATE,
        SNOOP_OTHER_WRITE
    } snoop_e;
endpackage

// ---- hw/snoop_match.sv ----
// decides whether a snooped event drops the reservation
`timescale 1ns/1ps
`default_nettype none
module snoop_match #(
    parameter int ADDR_W = resv_pkg::ADDR_W,
    parameter int GRANULE_BITS = resv_pkg::GRANULE_BITS,
    parameter bit CLEAR_OPTIONAL = 1'b1
) (
    input wire logic snoop_valid,
    input wire resv_pkg::snoop_e snoop_kind,
    input wire logic [ADDR_W-1:0] snoop_addr,
    input wire logic snoop_alloc_new,
    input wire logic resv_valid,
    input wire logic [ADDR_W-1:0] resv_addr,
    output logic kill
);
    logic same_granule;
    // low bits inside the granule are ignored
    assign same_granule = snoop_addr[ADDR_W-1:GRANULE_BITS] == resv_addr[ADDR_W-1:GRANULE_BITS];

    always_comb begin
        kill = 1'b0;
        if (snoop_valid && resv_valid && same_granule) begin
            case (snoop_kind)
                resv_pkg::SNOOP_STORE,
                resv_pkg::SNOOP_ZERO,
                resv_pkg::SNOOP_REF_CHG: kill = 1'b1;
                resv_pkg::SNOOP_OTHER_WRITE: kill = 1'b1;
                resv_pkg::SNOOP_TOUCH_STORE,
                resv_pkg::SNOOP_BLOCK_STORE,
                resv_pkg::SNOOP_FLUSH,
                resv_pkg::SNOOP_INVALIDATE: kill = CLEAR_OPTIONAL;
                resv_pkg::SNOOP_ALLOCATE: kill = snoop_alloc_new | CLEAR_OPTIONAL;
                default: kill = 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- hw/reservation_atomic_sync_unit.sv ----
// reservation tracking, conditional store and full barrier sequencing
`timescale 1ns/1ps
`default_nettype none
module reservation_atomic_sync_unit #(
    parameter int ADDR_W = resv_pkg::ADDR_W,
    parameter int DATA_W = resv_pkg::DATA_W,
    parameter int GRANULE_BITS = resv_pkg::GRANULE_BITS,
    parameter bit CLEAR_OPTIONAL = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst,
    // instruction issue from the pipeline
    input wire logic issue_valid,
    input wire resv_pkg::op_e issue_op,
    input wire logic [31:0] issue_instr,
    input wire logic [resv_pkg::REG_IDX_W-1:0] base_index,
    input wire logic [ADDR_W-1:0] base_register,
    input wire logic [ADDR_W-1:0] index_register,
    input wire logic [DATA_W-1:0] source_register,
    input wire logic [resv_pkg::REG_IDX_W-1:0] dest_index,
    // exception indication, deliberately unused by the reservation
    input wire logic exception_taken,
    // pipeline quiescence for the barrier
    input wire logic earlier_done,
    input wire logic mem_drained,
    // memory port
    input wire logic mem_ready,
    input wire logic mem_rvalid,
    input wire logic [DATA_W-1:0] mem_rdata,
    // snoop port from the shared memory system
    input wire logic snoop_valid,
    input wire resv_pkg::snoop_e snoop_kind,
    input wire logic [ADDR_W-1:0] snoop_addr,
    input wire logic snoop_alloc_new,
    // outputs
    output logic issue_ready,
    output logic mem_req,
    output logic mem_we,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [DATA_W-1:0] mem_wdata,
    output logic wb_valid,
    output logic [resv_pkg::REG_IDX_W-1:0] wb_index,
    output logic [DATA_W-1:0] wb_data,
    output logic cr_valid,
    output logic cr_success,
    output logic invalid_form,
    output logic barrier_active,
    output logic barrier_signal,
    output logic resv_valid,
    output logic [ADDR_W-1:0] resv_addr
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_LOAD_WAIT,
        ST_STORE,
        ST_BARRIER
    } state_e;

    state_e state;
    logic [ADDR_W-1:0] ea;
    logic [ADDR_W-1:0] base_eff;
    logic snoop_kill;
    logic take;
    logic [resv_pkg::REG_IDX_W-1:0] op_dest;
    logic store_hit;
    logic barrier_ok;

    assign base_eff = (base_index == resv_pkg::ZERO_BASE_IDX) ? '0 : base_register;
    assign ea = base_eff + index_register;
    assign take = issue_valid && issue_ready;
    assign barrier_ok = !issue_instr[resv_pkg::RECORD_BIT_POS];

    snoop_match #(
        .ADDR_W(ADDR_W),
        .GRANULE_BITS(GRANULE_BITS),
        .CLEAR_OPTIONAL(CLEAR_OPTIONAL)
    ) u_snoop (
        .snoop_valid(snoop_valid),
        .snoop_kind(snoop_kind),
        .snoop_addr(snoop_addr),
        .snoop_alloc_new(snoop_alloc_new),
        .resv_valid(resv_valid),
        .resv_addr(resv_addr),
        .kill(snoop_kill)
    );

    // sequencing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            issue_ready <= 1'b1;
            op_dest <= '0;
            store_hit <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        op_dest <= dest_index;
                        case (issue_op)
                            resv_pkg::OP_LOAD_RESERVE: begin
                                state <= ST_LOAD;
                                issue_ready <= 1'b0;
                            end
                            resv_pkg::OP_STORE_COND: begin
                                // a match needs a live reservation at this address
                                store_hit <= resv_valid && !snoop_kill
                                    && resv_addr == ea;
                                state <= ST_STORE;
                                issue_ready <= 1'b0;
                            end
                            resv_pkg::OP_FULL_BARRIER: begin
                                if (barrier_ok) begin
                                    state <= ST_BARRIER;
                                    issue_ready <= 1'b0;
                                end
                            end
                            default: state <= ST_IDLE;
                        endcase
                    end
                end
                ST_LOAD: begin
                    if (mem_ready) begin
                        state <= ST_LOAD_WAIT;
                    end
                end
                ST_LOAD_WAIT: begin
                    if (mem_rvalid) begin
                        state <= ST_IDLE;
                        issue_ready <= 1'b1;
                    end
                end
                ST_STORE: begin
                    if (!store_hit || mem_ready) begin
                        state <= ST_IDLE;
                        issue_ready <= 1'b1;
                    end
                end
                ST_BARRIER: begin
                    // complete only when earlier work and memory are settled
                    if (earlier_done && mem_drained) begin
                        state <= ST_IDLE;
                        issue_ready <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    issue_ready <= 1'b1;
                end
            endcase
        end
    end

    // memory request
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= '0;
        end else if (state == ST_IDLE && take && issue_op == resv_pkg::OP_LOAD_RESERVE) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= ea;
        end else if (state == ST_IDLE && take && issue_op == resv_pkg::OP_STORE_COND) begin
            // mismatch or no reservation: nothing reaches memory or cache
            mem_req <= resv_valid && !snoop_kill && resv_addr == ea;
            mem_we <= resv_valid && !snoop_kill && resv_addr == ea;
            mem_addr <= ea;
            mem_wdata <= source_register;
        end else if (mem_req && mem_ready) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
        end
    end

    // reservation: single address and valid flag; exception_taken never reaches it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            resv_valid <= resv_pkg::RESV_VALID_RST;
            resv_addr <= resv_pkg::RESV_ADDR_RST;
        end else if (state == ST_IDLE && take && issue_op == resv_pkg::OP_LOAD_RESERVE) begin
            resv_valid <= 1'b1;
            resv_addr <= ea;
        end else if (state == ST_IDLE && take && issue_op == resv_pkg::OP_STORE_COND) begin
            resv_valid <= 1'b0;
        end else if (snoop_kill) begin
            resv_valid <= 1'b0;
        end
    end

    // load writeback
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_valid <= 1'b0;
            wb_index <= '0;
            wb_data <= '0;
        end else begin
            wb_valid <= state == ST_LOAD_WAIT && mem_rvalid;
            if (state == ST_LOAD_WAIT && mem_rvalid) begin
                wb_index <= op_dest;
                wb_data <= mem_rdata;
            end
        end
    end

    // condition register success bit
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cr_valid <= 1'b0;
            cr_success <= 1'b0;
        end else begin
            cr_valid <= state == ST_STORE && (!store_hit || mem_ready);
            if (state == ST_STORE && (!store_hit || mem_ready)) begin
                cr_success <= store_hit;
            end
        end
    end

    // invalid form and barrier status
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            invalid_form <= 1'b0;
            barrier_active <= 1'b0;
            barrier_signal <= 1'b0;
        end else begin
            invalid_form <= state == ST_IDLE && take
                && issue_op == resv_pkg::OP_FULL_BARRIER && !barrier_ok;
            barrier_active <= (state == ST_IDLE && take
                && issue_op == resv_pkg::OP_FULL_BARRIER && barrier_ok)
                || (state == ST_BARRIER && !(earlier_done && mem_drained));
            barrier_signal <= state == ST_BARRIER && earlier_done && mem_drained;
        end
    end
endmodule
`default_nettype wire

// ---- sim/resv_monitor.sv ----
// port assertions for the reservation unit
`timescale 1ns/1ps
`default_nettype none
module resv_monitor #(
    parameter int ADDR_W = 32,
    parameter int GRANULE_BITS = 5
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire resv_pkg::op_e issue_op,
    input wire logic [31:0] issue_instr,
    input wire logic [4:0] base_index,
    input wire logic [ADDR_W-1:0] base_register,
    input wire logic [ADDR_W-1:0] index_register,
    input wire logic earlier_done,
    input wire logic mem_drained,
    input wire logic snoop_valid,
    input wire resv_pkg::snoop_e snoop_kind,
    input wire logic [ADDR_W-1:0] snoop_addr,
    input wire logic issue_ready,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic invalid_form,
    input wire logic barrier_active,
    input wire logic barrier_signal,
    input wire logic resv_valid,
    input wire logic [ADDR_W-1:0] resv_addr
);
    logic [ADDR_W-1:0] ea;
    logic ld, st, fb, hit;
    assign ea = (base_index == 5'h0 ? '0 : base_register) + index_register;
    assign ld = issue_valid && issue_ready && issue_op == resv_pkg::OP_LOAD_RESERVE;
    assign st = issue_valid && issue_ready && issue_op == resv_pkg::OP_STORE_COND;
    assign fb = issue_valid && issue_ready && issue_op == resv_pkg::OP_FULL_BARRIER;
    assign hit = snoop_valid && snoop_kind != resv_pkg::SNOOP_NONE
        && snoop_addr[ADDR_W-1:GRANULE_BITS] == resv_addr[ADDR_W-1:GRANULE_BITS];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_hit;
        st && resv_valid && resv_addr == ea && !snoop_valid;
    endsequence
    a_load_addr: assert property (ld |=> mem_req && !mem_we && mem_addr == $past(ea))
        else $error("load address wrong");
    a_resv_set: assert property (ld |=> resv_valid && resv_addr == $past(ea))
        else $error("reservation not set");
    a_store_write: assert property (s_hit |=> mem_req && mem_we && mem_addr == $past(ea))
        else $error("store not written");
    a_store_clear: assert property (st |=> !resv_valid)
        else $error("store kept reservation");
    a_miss_quiet: assert property (st && !(resv_valid && resv_addr == ea) |=> !mem_req [*2])
        else $error("failed store touched memory");
    a_snoop_kill: assert property (hit && resv_valid && !ld |=> !resv_valid)
        else $error("snoop did not clear");
    a_resv_keep: assert property (resv_valid && !hit && !ld && !st |=> resv_valid && $stable(resv_addr))
        else $error("reservation lost");
    a_bad_form: assert property (fb && issue_instr[resv_pkg::RECORD_BIT_POS] |=> invalid_form && !barrier_active)
        else $error("bad barrier accepted");
    a_barrier_done: assert property (barrier_active && !barrier_signal && earlier_done && mem_drained |-> ##[1:3] barrier_signal)
        else $error("barrier did not finish");
    a_barrier_hold: assert property (barrier_active && !(earlier_done && mem_drained) |=> barrier_active && !barrier_signal && !issue_ready)
        else $error("barrier ended early");
endmodule
bind reservation_atomic_sync_unit resv_monitor #(.ADDR_W(ADDR_W), .GRANULE_BITS(GRANULE_BITS)) mon (.*);
`default_nettype wire

// ---- sim/mem_model.sv ----
// memory partner answering the unit's memory port
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ready,
    output logic mem_rvalid,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [16];
    logic [3:0] idx;
    logic [1:0] waited;
    logic pend;
    always @(posedge ref_clk) begin
        mem_ready <= 1'b0;
        mem_rvalid <= pend;
        pend <= 1'b0;
        // idle data toggles so a stale word is never trusted
        mem_rdata <= pend ? mem[idx] : ~mem_rdata;
        if (rst) begin
            waited <= 2'h0;
            mem_rdata <= 32'h0;
            mem_rvalid <= 1'b0;
            for (int i = 0; i < 16; i++) mem[i] <= 32'h10000000 + i;
        end else if (mem_req && !mem_ready) begin
            waited <= waited + 2'h1;
            if (!slow || waited == 2'h3) begin
                mem_ready <= 1'b1;
                waited <= 2'h0;
                idx <= mem_addr[5:2];
                pend <= !mem_we;
                if (mem_we) mem[mem_addr[5:2]] <= mem_wdata;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sim/reservation_atomic_sync_unit_bench.sv ----
// bench for the reservation unit
`timescale 1ns/1ps
`default_nettype none
module reservation_atomic_sync_unit_bench;
    typedef struct {resv_pkg::op_e op; logic [4:0] bi; logic [31:0] b, x, s, res, w; logic [3:0] m;} row_s;
    localparam resv_pkg::op_e LD = resv_pkg::OP_LOAD_RESERVE, SC = resv_pkg::OP_STORE_COND;
    localparam resv_pkg::op_e FB = resv_pkg::OP_FULL_BARRIER;
    logic ref_clk = 1'b0, rst = 1'b1, issue_valid = 1'b0, exception_taken = 1'b0, slow = 1'b0;
    logic earlier_done = 1'b1, mem_drained = 1'b1, snoop_valid = 1'b0, snoop_alloc_new = 1'b1;
    logic [31:0] issue_instr = 32'h0, base_register = 32'h0, index_register = 32'h0, got;
    logic [31:0] source_register = 32'h0, snoop_addr = 32'h0, mem_rdata, mem_addr, mem_wdata;
    logic [31:0] wb_data, resv_addr;
    logic [4:0] base_index = 5'h0, dest_index = 5'h7, wb_index;
    resv_pkg::op_e issue_op = resv_pkg::OP_NONE;
    resv_pkg::snoop_e snoop_kind = resv_pkg::SNOOP_NONE;
    logic mem_ready, mem_rvalid, issue_ready, mem_req, mem_we, wb_valid, cr_valid, cr_success;
    logic invalid_form, barrier_active, barrier_signal, resv_valid;
    int n_errors = 0;
    int tests_run = 0;
    // word-aligned addresses; reserves and conditional stores, two of which fail, then two barriers
    row_s rows [10] = '{
        '{LD, 5'h0, 32'hdead0000, 32'h44, 32'h0, 32'h10000001, 32'h10000001, 4'h1},
        '{SC, 5'h3, 32'h40, 32'h4, 32'haaaa5555, 32'h1, 32'haaaa5555, 4'h1},
        '{SC, 5'h3, 32'h40, 32'h4, 32'h12345678, 32'h0, 32'haaaa5555, 4'h1},
        '{LD, 5'h1, 32'h40, 32'h8, 32'h0, 32'h10000002, 32'h10000002, 4'h2},
        '{LD, 5'h1, 32'h40, 32'hc, 32'h0, 32'h10000003, 32'h10000003, 4'h3},
        '{SC, 5'h1, 32'h40, 32'h8, 32'h5a5a5a5a, 32'h0, 32'h10000002, 4'h2},
        '{LD, 5'h2, 32'h50, 32'h0, 32'h0, 32'h10000004, 32'h10000004, 4'h4},
        '{SC, 5'h2, 32'h50, 32'h0, 32'h0f0f0f0f, 32'h1, 32'h0f0f0f0f, 4'h4},
        '{FB, 5'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h10000000, 4'h0},
        '{FB, 5'h0, 32'h0, 32'h0, 32'h80000000, 32'h2, 32'h10000000, 4'h0}};
    reservation_atomic_sync_unit dut (.*);
    mem_model mdl (.*);
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic do_op(input row_s r);
        @(posedge ref_clk);
        issue_valid <= 1'b1;
        issue_op <= r.op;
        base_index <= r.bi;
        base_register <= r.b;
        index_register <= r.x;
        source_register <= r.s;
        issue_instr <= r.s;
        dest_index <= ~r.bi;
        @(posedge ref_clk);
        issue_valid <= 1'b0;
        got = 'x;
        repeat (30) begin
            @(negedge ref_clk);
            if (wb_valid === 1'b1) begin
                got = wb_data;
                check("wb index", 32'(wb_index ^ r.bi), 32'h1f);
            end
            if (cr_valid === 1'b1) got = 32'(cr_success);
            if (barrier_signal === 1'b1) got = 32'h1;
            if (invalid_form === 1'b1) got = 32'h2;
            if (issue_ready === 1'b1) break;
        end
    endtask
    task automatic snoop(input resv_pkg::snoop_e k, input logic [31:0] a);
        @(posedge ref_clk);
        snoop_valid <= 1'b1;
        snoop_kind <= k;
        snoop_addr <= a;
        exception_taken <= 1'b1;
        @(posedge ref_clk);
        snoop_valid <= 1'b0;
        snoop_addr <= ~a;
        exception_taken <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            do_op(rows[i]);
            check("result", got, rows[i].res);
            check("memory", mdl.mem[rows[i].m], rows[i].w);
            $display("row %0d done", i);
        end
        slow <= 1'b1;
        for (int k = 1; k < 10; k++) begin
            do_op(rows[0]);
            snoop(resv_pkg::snoop_e'(k), 32'h5c);
            check("snoop kill", 32'(resv_valid), 32'h0);
        end
        do_op(rows[0]);
        snoop(resv_pkg::SNOOP_STORE, 32'h60);
        check("keep", 32'(resv_valid), 32'h1);
        do_op(rows[1]);
        check("keep store", got, 32'h1);
        $display("snoop test done");
        @(posedge ref_clk);
        earlier_done <= 1'b0;
        mem_drained <= 1'b0;
        fork
            do_op(rows[8]);
            begin
                repeat (6) @(negedge ref_clk);
                check("stall", 32'({barrier_active, issue_ready, barrier_signal}), 32'h4);
                @(posedge ref_clk);
                earlier_done <= 1'b1;
                repeat (3) @(negedge ref_clk);
                check("drain", 32'({barrier_active, issue_ready, barrier_signal}), 32'h4);
                @(posedge ref_clk);
                mem_drained <= 1'b1;
            end
        join
        check("barrier", got, 32'h1);
        do_op(rows[0]);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        check("reset", 32'({issue_ready, resv_valid, mem_req, wb_valid, cr_valid, invalid_form,
            barrier_active, barrier_signal}), 32'h80);
        $display("barrier and reset tests done");
        final_report();
    end
endmodule
`default_nettype wire
